// ==== design/zsf_cfg.svh ====
// Purpose: Offsets, field positions and reset values of the zoom regs
// Assumes: Byte address is four times the register index
// Notes:   Definitions only
`ifndef ZSF_CFG_SVH
`define ZSF_CFG_SVH

`define ZSF_IDX_HHIGH    6'h13
`define ZSF_IDX_HLOW     6'h14
`define ZSF_IDX_VHIGH    6'h15
`define ZSF_IDX_VLOW     6'h16
`define ZSF_IDX_FILT     6'h17
`define ZSF_IDX_STAT     6'h20

`define ZSF_CASC_BIT     7
`define ZSF_RSVD_BIT     6
`define ZSF_OFS_MSB      5
`define ZSF_HHIGH_MSB    8

`define ZSF_ST_PEND      0
`define ZSF_ST_HNOZ      1
`define ZSF_ST_VNOZ      2
`define ZSF_ST_CASC      3

`define ZSF_RST_HHIGH    9'h000
`define ZSF_RST_BYTE     8'h00
`define ZSF_RST_OFS      6'h00

`define ZSF_RESP_OKAY    2'h0
`define ZSF_RESP_SLVERR  2'h2

`endif

// ==== design/zsf_pkg.sv ====
// Purpose: Types shared by the zoom scale and filter register slice
// Assumes: Nothing beyond the cfg header
// Notes:   Scale values travel as one packed struct
package zsf_pkg;

  typedef enum logic [2:0] {
    REG_HHIGH,
    REG_HLOW,
    REG_VHIGH,
    REG_VLOW,
    REG_FILT,
    REG_STAT,
    REG_NONE
  } zsf_reg_e;

  typedef struct packed {
    logic       cascadeEnable;
    logic [5:0] subpixelOffset;
  } zsf_filter_s;

  typedef struct packed {
    logic [16:0] horizontalScaleValue;
    logic [15:0] verticalScaleValue;
    zsf_filter_s filter;
  } zsf_scale_s;

endpackage

// ==== design/zsf_shadow.sv ====
// Purpose: Frame-aligned copy of the programmed scale settings
// Assumes: load is a one-cycle pulse at a frame boundary
// Notes:   All fields are taken together
`timescale 1ns/10ps
module zsf_shadow #(
  parameter int WIDTH = 40
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] liveValue,
  output logic      [WIDTH-1:0] heldValue
);

  logic [WIDTH-1:0] held_ff;
  logic [WIDTH-1:0] nxt_held;

  always_comb begin
    nxt_held = load ? liveValue : held_ff;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      held_ff <= '0;
    end else begin
      held_ff <= nxt_held;
    end
  end

  assign heldValue = held_ff;

endmodule

// ==== design/zsf_scale_out.sv ====
// Purpose: Registers scale settings and no-zoom flags for the datapath
// Assumes: applied changes only at frame boundaries
// Notes:   Offset reads zero to the datapath while cascading is off
`timescale 1ns/10ps
`include "zsf_cfg.svh"
module zsf_scale_out
  import zsf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire zsf_scale_s applied,
  output zsf_scale_s      scaleOut,
  output logic            horizNoZoom,
  output logic            vertNoZoom
);

  zsf_scale_s scale_ff;
  zsf_scale_s nxt_scale;
  logic       hNoZoom_ff;
  logic       vNoZoom_ff;
  logic       nxt_hNoZoom;
  logic       nxt_vNoZoom;

  always_comb begin
    nxt_scale = applied;
    if (!applied.filter.cascadeEnable) begin
      nxt_scale.filter.subpixelOffset = `ZSF_RST_OFS;
    end
    nxt_hNoZoom = (applied.horizontalScaleValue == '0);
    nxt_vNoZoom = (applied.verticalScaleValue == '0);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scale_ff   <= '0;
      hNoZoom_ff <= 1'b1;
      vNoZoom_ff <= 1'b1;
    end else begin
      scale_ff   <= nxt_scale;
      hNoZoom_ff <= nxt_hNoZoom;
      vNoZoom_ff <= nxt_vNoZoom;
    end
  end

  assign scaleOut    = scale_ff;
  assign horizNoZoom = hNoZoom_ff;
  assign vertNoZoom  = vNoZoom_ff;

endmodule

// ==== design/zsf_regs.sv ====
// Purpose: AXI4-Lite register slice for zoom scale and filter control
// Assumes: frameStart is a one-cycle pulse at each output frame start
// Notes:   Scale values reach the datapath only at frame boundaries
// Function
// - 8-bit read/write register at index 0x14 holds horizontal low byte.
// - Horizontal scale is 17 bits: 9 high-register bits over 8 low bits.
// - Vertical scale is 16 bits: index 0x15 upper byte, 0x16 lower byte.
// - Non-interlaced vertical value means input/output line ratio times 2^16.
// - All-zero vertical scale registers select one-to-one vertical scaling.
// - All-zero horizontal scale registers mean no horizontal zoom.
// - Interlaced input is de-interlaced; value uses the field-line formula.
// - With cascading on, filter bits 5:0 set the sub-pixel offset.
// - Filter bit 7 selects normal filtering at zero, cascading at one.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "zsf_cfg.svh"
module zsf_regs
  import zsf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              frameStart,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output zsf_scale_s             scaleOut,
  output logic                   horizNoZoom,
  output logic                   vertNoZoom
);

  function automatic zsf_reg_e zsfDecode(input logic [ADDR_W-1:0] a);
    zsf_reg_e sel;
    case (a[ADDR_W-1:2])
      `ZSF_IDX_HHIGH: sel = REG_HHIGH;
      `ZSF_IDX_HLOW:  sel = REG_HLOW;
      `ZSF_IDX_VHIGH: sel = REG_VHIGH;
      `ZSF_IDX_VLOW:  sel = REG_VLOW;
      `ZSF_IDX_FILT:  sel = REG_FILT;
      `ZSF_IDX_STAT:  sel = REG_STAT;
      default:        sel = REG_NONE;
    endcase
    return sel;
  endfunction

  // Write channel
  logic              awHeld_ff;
  logic              wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              awready_ff;
  logic              wready_ff;
  logic              nxt_awHeld;
  logic              nxt_wHeld;
  logic [ADDR_W-1:0] nxt_awAddr;
  logic [31:0]       nxt_wData;
  logic [3:0]        nxt_wStrb;
  logic              nxt_bvalid;
  logic [1:0]        nxt_bresp;
  logic              nxt_awready;
  logic              nxt_wready;
  logic              awAcc;
  logic              wAcc;
  logic              doWrite;
  logic [ADDR_W-1:0] curAddr;
  logic [31:0]       curData;
  logic [3:0]        curStrb;
  zsf_reg_e          wrSel;

  always_comb begin
    awAcc      = s_axi_awvalid & awready_ff;
    wAcc       = s_axi_wvalid & wready_ff;
    curAddr    = awAcc ? s_axi_awaddr : awAddr_ff;
    curData    = wAcc ? s_axi_wdata : wData_ff;
    curStrb    = wAcc ? s_axi_wstrb : wStrb_ff;
    wrSel      = zsfDecode(curAddr);
    doWrite    = (awHeld_ff | awAcc) & (wHeld_ff | wAcc) & ~bvalid_ff;
    nxt_awHeld = (awHeld_ff | awAcc) & ~doWrite;
    nxt_wHeld  = (wHeld_ff | wAcc) & ~doWrite;
    nxt_awAddr = curAddr;
    nxt_wData  = curData;
    nxt_wStrb  = curStrb;
    nxt_bvalid = doWrite | (bvalid_ff & ~s_axi_bready);
    nxt_bresp  = bresp_ff;
    if (doWrite) begin
      // Unmapped and read-only targets answer with an error
      if (wrSel == REG_NONE || wrSel == REG_STAT) begin
        nxt_bresp = `ZSF_RESP_SLVERR;
      end else begin
        nxt_bresp = `ZSF_RESP_OKAY;
      end
    end
    nxt_awready = ~nxt_awHeld & ~nxt_bvalid;
    nxt_wready  = ~nxt_wHeld & ~nxt_bvalid;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awAddr_ff  <= '0;
      wData_ff   <= '0;
      wStrb_ff   <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ZSF_RESP_OKAY;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      awHeld_ff  <= nxt_awHeld;
      wHeld_ff   <= nxt_wHeld;
      awAddr_ff  <= nxt_awAddr;
      wData_ff   <= nxt_wData;
      wStrb_ff   <= nxt_wStrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
    end
  end

  // Programmed registers
  logic [8:0]  hHigh_ff;
  logic [7:0]  hLow_ff;
  logic [7:0]  vHigh_ff;
  logic [7:0]  vLow_ff;
  zsf_filter_s filt_ff;
  logic        pending_ff;
  logic [8:0]  nxt_hHigh;
  logic [7:0]  nxt_hLow;
  logic [7:0]  nxt_vHigh;
  logic [7:0]  nxt_vLow;
  zsf_filter_s nxt_filt;
  logic        nxt_pending;
  logic        setWrite;

  always_comb begin
    nxt_hHigh = hHigh_ff;
    nxt_hLow  = hLow_ff;
    nxt_vHigh = vHigh_ff;
    nxt_vLow  = vLow_ff;
    nxt_filt  = filt_ff;
    setWrite  = 1'b0;
    if (doWrite) begin
      unique case (wrSel)
        REG_HHIGH: begin
          if (curStrb[0]) nxt_hHigh[7:0] = curData[7:0];
          if (curStrb[1]) nxt_hHigh[8] = curData[`ZSF_HHIGH_MSB];
          setWrite = |curStrb[1:0];
        end
        REG_HLOW: begin
          if (curStrb[0]) nxt_hLow = curData[7:0];
          setWrite = curStrb[0];
        end
        REG_VHIGH: begin
          if (curStrb[0]) nxt_vHigh = curData[7:0];
          setWrite = curStrb[0];
        end
        REG_VLOW: begin
          if (curStrb[0]) nxt_vLow = curData[7:0];
          setWrite = curStrb[0];
        end
        REG_FILT: begin
          if (curStrb[0]) begin
            nxt_filt.cascadeEnable  = curData[`ZSF_CASC_BIT];
            nxt_filt.subpixelOffset = curData[`ZSF_OFS_MSB:0];
          end
          setWrite = curStrb[0];
        end
        REG_STAT, REG_NONE: setWrite = 1'b0;
      endcase
    end
    // A write in the load cycle stays pending for the next frame
    nxt_pending = setWrite | (pending_ff & ~frameStart);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hHigh_ff   <= `ZSF_RST_HHIGH;
      hLow_ff    <= `ZSF_RST_BYTE;
      vHigh_ff   <= `ZSF_RST_BYTE;
      vLow_ff    <= `ZSF_RST_BYTE;
      filt_ff    <= '0;
      pending_ff <= 1'b0;
    end else begin
      hHigh_ff   <= nxt_hHigh;
      hLow_ff    <= nxt_hLow;
      vHigh_ff   <= nxt_vHigh;
      vLow_ff    <= nxt_vLow;
      filt_ff    <= nxt_filt;
      pending_ff <= nxt_pending;
    end
  end

  // Frame-aligned transfer to the datapath
  zsf_scale_s liveScale;
  zsf_scale_s appliedScale;
  logic [$bits(zsf_scale_s)-1:0] appliedBits;

  always_comb begin
    liveScale.horizontalScaleValue = {hHigh_ff, hLow_ff};
    liveScale.verticalScaleValue   = {vHigh_ff, vLow_ff};
    liveScale.filter               = filt_ff;
  end

  zsf_shadow #(
    .WIDTH ($bits(zsf_scale_s))
  ) zsf_shadow_i (
    .mclk      (mclk),
    .resetn    (resetn),
    .load      (frameStart),
    .liveValue (liveScale),
    .heldValue (appliedBits)
  );

  assign appliedScale = zsf_scale_s'(appliedBits);

  zsf_scale_out zsf_scale_out_i (
    .mclk        (mclk),
    .resetn      (resetn),
    .applied     (appliedScale),
    .scaleOut    (scaleOut),
    .horizNoZoom (horizNoZoom),
    .vertNoZoom  (vertNoZoom)
  );

  // Read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        arready_ff;
  logic        nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;
  logic        nxt_arready;
  logic        arAcc;
  zsf_reg_e    rdSel;
  logic [31:0] readMux;

  always_comb begin
    arAcc   = s_axi_arvalid & arready_ff;
    rdSel   = zsfDecode(s_axi_araddr);
    readMux = '0;
    unique case (rdSel)
      REG_HHIGH: readMux[8:0] = hHigh_ff;
      REG_HLOW:  readMux[7:0] = hLow_ff;
      REG_VHIGH: readMux[7:0] = vHigh_ff;
      REG_VLOW:  readMux[7:0] = vLow_ff;
      REG_FILT: begin
        readMux[`ZSF_CASC_BIT]  = filt_ff.cascadeEnable;
        readMux[`ZSF_OFS_MSB:0] = filt_ff.subpixelOffset;
      end
      REG_STAT: begin
        readMux[`ZSF_ST_PEND] = pending_ff;
        readMux[`ZSF_ST_HNOZ] = horizNoZoom;
        readMux[`ZSF_ST_VNOZ] = vertNoZoom;
        readMux[`ZSF_ST_CASC] = scaleOut.filter.cascadeEnable;
      end
      REG_NONE: readMux = '0;
    endcase
    nxt_rvalid  = arAcc | (rvalid_ff & ~s_axi_rready);
    nxt_rdata   = arAcc ? readMux : rdata_ff;
    nxt_rresp   = rresp_ff;
    if (arAcc) begin
      nxt_rresp = (rdSel == REG_NONE) ? `ZSF_RESP_SLVERR : `ZSF_RESP_OKAY;
    end
    nxt_arready = ~nxt_rvalid;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= `ZSF_RESP_OKAY;
      arready_ff <= 1'b0;
    end else begin
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      arready_ff <= nxt_arready;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Checks
  property p_hlow_store;
    @(posedge mclk) disable iff (!resetn)
    doWrite && wrSel == REG_HLOW && curStrb[0] |=>
      hLow_ff == $past(curData[7:0]);
  endproperty
  a_hlow_store: assert property (p_hlow_store)
    else $error("horizontal low byte not stored");

  property p_hscale_join;
    @(posedge mclk) disable iff (!resetn)
    frameStart |-> ##2
      scaleOut.horizontalScaleValue == $past({hHigh_ff, hLow_ff}, 2);
  endproperty
  a_hscale_join: assert property (p_hscale_join)
    else $error("horizontal scale not assembled from both halves");

  property p_vscale_join;
    @(posedge mclk) disable iff (!resetn)
    frameStart |-> ##2
      scaleOut.verticalScaleValue == $past({vHigh_ff, vLow_ff}, 2);
  endproperty
  a_vscale_join: assert property (p_vscale_join)
    else $error("vertical scale not assembled from both halves");

  property p_vert_nozoom;
    @(posedge mclk) disable iff (!resetn)
    appliedScale.verticalScaleValue == '0 |=> vertNoZoom;
  endproperty
  a_vert_nozoom: assert property (p_vert_nozoom)
    else $error("vertical no-zoom flag missing");

  property p_horiz_nozoom;
    @(posedge mclk) disable iff (!resetn)
    appliedScale.horizontalScaleValue != '0 |=> !horizNoZoom;
  endproperty
  a_horiz_nozoom: assert property (p_horiz_nozoom)
    else $error("horizontal no-zoom flag set for nonzero value");

  property p_offset_gate;
    @(posedge mclk) disable iff (!resetn)
    !scaleOut.filter.cascadeEnable |-> scaleOut.filter.subpixelOffset == 0;
  endproperty
  a_offset_gate: assert property (p_offset_gate)
    else $error("sub-pixel offset active without cascading");

  property p_cascade_sel;
    @(posedge mclk) disable iff (!resetn)
    frameStart |-> ##2
      scaleOut.filter.cascadeEnable == $past(filt_ff.cascadeEnable, 2);
  endproperty
  a_cascade_sel: assert property (p_cascade_sel)
    else $error("cascade enable not applied");

  property p_frame_hold;
    @(posedge mclk) disable iff (!resetn)
    !$past(frameStart, 2) |-> $stable(scaleOut);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("scale output changed between frames");

  property p_pending_set;
    @(posedge mclk) disable iff (!resetn)
    setWrite |=> pending_ff ##1 (pending_ff || $past(frameStart));
  endproperty
  a_pending_set: assert property (p_pending_set)
    else $error("pending update lost");

  property p_write_resp;
    @(posedge mclk) disable iff (!resetn)
    doWrite |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing");

  c_vert_zoom: cover property (@(posedge mclk) disable iff (!resetn)
    frameStart ##2 !vertNoZoom);
  c_cascade: cover property (@(posedge mclk) disable iff (!resetn)
    scaleOut.filter.cascadeEnable && scaleOut.filter.subpixelOffset != 0);
  c_pend_race: cover property (@(posedge mclk) disable iff (!resetn)
    setWrite && frameStart);

endmodule

// ==== dv/tb_zsf_regs.sv ====
// Purpose: Self-checking bench for the zoom scale and filter register slice
// Assumes: Register bus master drives by non-blocking assignment at mclk rise
// Notes:   Drivers queue expected results; a monitor pops and compares them
`timescale 1ns/10ps
`include "zsf_cfg.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  fails++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_zsf_regs
  import zsf_pkg::*;
;
  localparam logic [7:0] A_HH = {`ZSF_IDX_HHIGH, 2'b00};
  localparam logic [7:0] A_HL = {`ZSF_IDX_HLOW, 2'b00};
  localparam logic [7:0] A_VH = {`ZSF_IDX_VHIGH, 2'b00};
  localparam logic [7:0] A_VL = {`ZSF_IDX_VLOW, 2'b00};
  localparam logic [7:0] A_FC = {`ZSF_IDX_FILT, 2'b00};
  localparam logic [7:0] A_ST = {`ZSF_IDX_STAT, 2'b00};
  localparam logic [1:0] OK   = `ZSF_RESP_OKAY;
  localparam logic [1:0] ERR  = `ZSF_RESP_SLVERR;

  logic        mclk, resetn, frameStart;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  zsf_scale_s  scaleOut, lastOut;
  logic        horizNoZoom, vertNoZoom;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [41:0] oq[$];
  logic [33:0] er;
  logic [1:0]  eb;
  logic [41:0] eo;
  logic [2:0]  fsp;
  logic [16:0] hv, aH;
  logic [15:0] vv, aV;
  logic [7:0]  fv;
  logic        aC;
  logic [31:0] r1, r2;
  int          fails, compares, cycles;

  zsf_regs #(.ADDR_W(8)) zsf_regs_i (
    .mclk(mclk), .resetn(resetn), .frameStart(frameStart),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .scaleOut(scaleOut),
    .horizNoZoom(horizNoZoom), .vertNoZoom(vertNoZoom)
  );

  initial begin
    mclk = 1'b0;
  end
  always #25 mclk = ~mclk;

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  // Monitor: each result pops the oldest note
  always @(posedge mclk) begin
    fsp <= resetn ? {fsp[1:0], frameStart} : 3'h0;
    if (s_axi_bvalid && s_axi_bready) begin
      eb = (bq.size() > 0) ? bq.pop_front() : 2'h1;
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = (rq.size() > 0) ? rq.pop_front() : 34'h1;
      `CHK("rdata", er, {s_axi_rdata, s_axi_rresp})
    end
    if (fsp[2]) begin
      eo = (oq.size() > 0) ? oq.pop_front() : 42'h1;
      `CHK("scaleOut", eo, {scaleOut, horizNoZoom, vertNoZoom})
    end
  end

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] r);
    logic awOk;
    logic wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    @(posedge mclk);
    bq.push_back(r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge mclk);
      if (!awOk && s_axi_awready) begin
        awOk = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wOk && s_axi_wready) begin
        wOk = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
    @(posedge mclk);
    rq.push_back({d, r});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chkAll(input logic pend);
    axiRd(A_HH, {23'h0, hv[16:8]}, OK);
    axiRd(A_HL, {24'h0, hv[7:0]}, OK);
    axiRd(A_VH, {24'h0, vv[15:8]}, OK);
    axiRd(A_VL, {24'h0, vv[7:0]}, OK);
    axiRd(A_FC, {24'h0, fv}, OK);
    axiRd(A_ST, {28'h0, aC, aV == 16'h0, aH == 17'h0, pend}, OK);
  endtask

  task automatic frame();
    zsf_scale_s e;
    e = {hv, vv, fv[7], fv[7] ? fv[5:0] : 6'h00};
    @(posedge mclk);
    oq.push_back({e, hv == 17'h0, vv == 16'h0});
    frameStart <= 1'b1;
    @(posedge mclk);
    frameStart <= 1'b0;
    aH = hv;
    aV = vv;
    aC = fv[7];
    lastOut = e;
    repeat (3) @(posedge mclk);
  endtask

  task automatic setAll(input logic [16:0] h, input logic [15:0] v,
                        input logic [7:0] f);
    hv = h;
    vv = v;
    fv = {f[7], 1'b0, f[5:0]};
    axiWr(A_HH, {23'h0, h[16:8]}, 4'hF, OK);
    axiWr(A_HL, {24'h0, h[7:0]}, 4'hF, OK);
    axiWr(A_VH, {24'h0, v[15:8]}, 4'hF, OK);
    axiWr(A_VL, {24'h0, v[7:0]}, 4'hF, OK);
    axiWr(A_FC, {24'h0, f}, 4'hF, OK);
    `CHK("held", lastOut, scaleOut)
    chkAll(1'b1);
    `CHK("held", lastOut, scaleOut)
    frame();
    chkAll(1'b0);
  endtask

  initial begin
    {resetn, frameStart, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
    s_axi_wdata = 32'h0;
    fails = 0;
    compares = 0;
    cycles = 0;
    {hv, vv, fv, aH, aV, aC} = 75'h0;
    lastOut = '0;
    r1 = $urandom(32'hBA0B1406);
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    `CHK("rstOut", {40'h0, 2'b11}, {scaleOut, horizNoZoom, vertNoZoom})
    `CHK("rstRdy", 3'h0, {s_axi_awready, s_axi_wready, s_axi_arready})
    chkAll(1'b0);
    axiRd(8'h00, 32'h0, ERR);
    axiRd(8'h60, 32'h0, ERR);
    axiWr(A_ST, 32'hFFFF_FFFF, 4'hF, ERR);
    axiWr(8'h04, 32'hFFFF_FFFF, 4'hF, ERR);
    axiWr(A_VL, 32'h0000_00FF, 4'h0, OK);
    chkAll(1'b0);
    setAll(17'h14000, 16'hA000, 8'h00);
    setAll(17'h14000, 16'h9FE0, 8'h00);
    setAll(17'h00000, 16'h4FF0, 8'hBF);
    setAll(17'h1FFFF, 16'h0000, 8'h95);
    setAll(17'h00000, 16'h0000, 8'h80);
    for (int i = 0; i < 6; i++) begin
      r1 = $urandom();
      r2 = $urandom();
      r2[7:0] = r2[7] ? {2'b10, r2[5:0]} : 8'h00;
      setAll(r1[16:0], r1[31:16], r2[7:0]);
    end
    axiWr(A_HH, 32'h0000_0000, 4'h2, OK);
    hv[16] = 1'b0;
    axiWr(A_HH, 32'h0000_01AB, 4'h1, OK);
    hv[15:8] = 8'hAB;
    chkAll(1'b1);
    frame();
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    {hv, vv, fv, aH, aV, aC} = 75'h0;
    lastOut = '0;
    `CHK("rstOut", {40'h0, 2'b11}, {scaleOut, horizNoZoom, vertNoZoom})
    `CHK("rstRdy", 3'h0, {s_axi_awready, s_axi_wready, s_axi_arready})
    chkAll(1'b0);
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule
